//--- dual_timer_defs.svh
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// Register byte offsets, compared against haddr[7:0].
`define OFS_LOWER_CTRL 8'h00
`define OFS_UPPER_CTRL 8'h04
`define OFS_LOWER_COUNT 8'h08
`define OFS_UPPER_COUNT 8'h0C
`define OFS_LOWER_PERIOD 8'h10
`define OFS_UPPER_PERIOD 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_CONFIG 8'h1C

// Control register field positions.
`define CTRL_RUN_BIT 15
`define CTRL_STOP_IDLE_BIT 13
`define CTRL_GATE_BIT 6
`define CTRL_PRESCALE_LSB 4
`define CTRL_PAIR_BIT 3
`define CTRL_SOURCE_BIT 1
`define CTRL_WMASK 16'hA07A

// Interrupt status and configuration field positions.
`define STAT_LOWER_BIT 0
`define STAT_UPPER_BIT 1
`define CFG_LOWER_EN_BIT 0
`define CFG_UPPER_EN_BIT 1
`define CFG_LOWER_PRIO_LSB 4
`define CFG_UPPER_PRIO_LSB 8
`define CFG_WMASK 16'h0773

// Reset values.
`define CTRL_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define PERIOD_RESET 16'hFFFF
`define CFG_RESET 16'h0000

// Prescaler terminal counts for ratios 1, 8, 64 and 256.
`define PS_TERM_DIV1 8'h00
`define PS_TERM_DIV8 8'h07
`define PS_TERM_DIV64 8'h3F
`define PS_TERM_DIV256 8'hFF

`endif

//--- dual_timer_pkg.sv
package dual_timer_pkg;

  // One timer's control word, laid out as software sees it.
  typedef struct packed {
    logic timer_run;
    logic rsvd14;
    logic stop_in_idle;
    logic [5:0] rsvd12_7;
    logic gated_count_enable;
    logic [1:0] prescale_select;
    logic pair_mode_select;
    logic rsvd2;
    logic clock_source_select;
    logic rsvd0;
  } timer_control_generic_type;

  // Pins of one timer: external count clock and gate.
  typedef struct packed {
    logic ext_clk;
    logic gate;
  } timer_pins_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RWAIT = 2'b10,
    BUS_RDONE = 2'b11
  } bus_state_type;

endpackage

//--- timer_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_defs.svh"

module timer_tick_gen #(
  parameter int PS_WIDTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire dual_timer_pkg::timer_control_generic_type ctrl_in,
  input wire logic enable_in,
  input wire dual_timer_pkg::timer_pins_type pins_in,
  output logic tick_out
);
  import dual_timer_pkg::*;

  timer_pins_type sync1_q;
  timer_pins_type sync2_q;
  logic clk_prev_q;
  logic [PS_WIDTH-1:0] ps_q;
  logic [PS_WIDTH-1:0] ps_d;
  logic [PS_WIDTH-1:0] term;
  logic src_event;

  // Refused at elaboration: a narrower prescaler cannot reach the ratio of 256.
  if (PS_WIDTH < 8) begin : g_bad_width
    $error("timer_tick_gen: PS_WIDTH must hold a ratio of 256.");
  end

  // Terminal count of the prescaler for the selected ratio.
  function automatic logic [PS_WIDTH-1:0] ps_term(input logic [1:0] sel);
    case (sel)
      2'b00: ps_term = PS_WIDTH'(`PS_TERM_DIV1);
      2'b01: ps_term = PS_WIDTH'(`PS_TERM_DIV8);
      2'b10: ps_term = PS_WIDTH'(`PS_TERM_DIV64);
      default: ps_term = PS_WIDTH'(`PS_TERM_DIV256);
    endcase
  endfunction

  // source and gate choose which events feed the prescaler.
  // a gated count advances only while the gate pin is high.
  always_comb begin
    term = ps_term(ctrl_in.prescale_select);
    if (ctrl_in.clock_source_select) begin
      src_event = sync2_q.ext_clk & ~clk_prev_q;
    end else if (ctrl_in.gated_count_enable) begin
      src_event = sync2_q.gate;
    end else begin
      src_event = 1'b1;
    end
    ps_d = ps_q;
    tick_out = 1'b0;
    // divide the source events by the selected ratio.
    if (!enable_in) begin
      ps_d = '0;
    end else if (src_event) begin
      if (ps_q == term) begin
        ps_d = '0;
        tick_out = 1'b1;
      end else begin
        ps_d = ps_q + PS_WIDTH'(1);
      end
    end
  end

  // Pins cross into the clock domain through two flops; edges use the second.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      clk_prev_q <= 1'b0;
      ps_q <= '0;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q.ext_clk;
      ps_q <= ps_d;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  chk_gate_blocks_tick: assert property (
    (!ctrl_in.clock_source_select && ctrl_in.gated_count_enable && !sync2_q.gate) |-> !tick_out)
    else $error("Tick produced while the gate was low.");
  chk_ext_edge_only: assert property (
    (ctrl_in.clock_source_select && !(sync2_q.ext_clk && !clk_prev_q)) |-> !tick_out)
    else $error("Tick without an external clock edge.");

endmodule
`default_nettype wire

//--- dual_timer.sv
// Behaviour
// - One 32-bit timer, or two independent 16-bit timers.
// - Configurations: two 16-bit timers, 32-bit timer, 32-bit synchronous counter.
// - Split timers support all modes except asynchronous external counting.
// - Each 16-bit timer works as synchronous timer or synchronous counter.
// - In 32-bit mode upper control is ignored; lower control governs.
// - In 32-bit mode the lower timer's clock and gate drive counting.
// - In 32-bit mode interrupts appear on the upper timer's flag and enable.
// - Lower count is the low word, upper count the high word.
// - Upper period is the high word, lower period the low word.
// - The 32-bit count is readable any time from the count pair.
// - Lower control bit 3 selects paired 32-bit operation.
// - Control bit 15 starts counting; software sets it last.
// - Two-bit prescale field divides the timer's input clock.
// - Clock source and gate enable bits choose source and gating.
// - Interrupt when the 32-bit count matches the 32-bit period.
// - Only the upper timer produces the converter trigger.
// - Timers keep running in idle and sleep unless their stop-in-idle bit is set.
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_defs.svh"

module dual_timer #(
  parameter int PS_WIDTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire dual_timer_pkg::timer_pins_type lower_pins_in,
  input wire dual_timer_pkg::timer_pins_type upper_pins_in,
  input wire logic idle_in,
  output logic lower_irq_out,
  output logic upper_irq_out,
  output logic [2:0] lower_irq_priority_out,
  output logic [2:0] upper_irq_priority_out,
  output logic adc_trigger_out
);
  import dual_timer_pkg::*;

  bus_state_type bus_q;
  bus_state_type bus_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic [15:0] rd_word;
  logic accept;
  logic wr_en;

  timer_control_generic_type lower_timer_control_q;
  timer_control_generic_type lower_timer_control_d;
  timer_control_generic_type upper_timer_control_q;
  timer_control_generic_type upper_timer_control_d;
  logic [15:0] lower_count_q;
  logic [15:0] lower_count_d;
  logic [15:0] upper_count_q;
  logic [15:0] upper_count_d;
  logic [15:0] lower_period_q;
  logic [15:0] lower_period_d;
  logic [15:0] upper_period_q;
  logic [15:0] upper_period_d;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic [15:0] irq_cfg_q;
  logic [15:0] irq_cfg_d;
  logic adc_q;
  logic adc_d;

  logic pair;
  logic lower_enable;
  logic upper_enable;
  logic tick_lo;
  logic tick_up;
  logic lo_match;
  logic up_match;
  logic [16:0] lo_step;
  logic [16:0] up_step;
  logic [31:0] count32;
  logic [31:0] period32;
  logic [1:0] clr;

  // One 16-bit step: returns {match, next count}.
  function automatic logic [16:0] step16(input logic [15:0] cnt, input logic [15:0] per);
    if (cnt == per) begin
      step16 = {1'b1, 16'h0000};
    end else begin
      step16 = {1'b0, cnt + 16'h0001};
    end
  endfunction

  // the pairing bit in the lower control word selects 32-bit operation.
  assign pair = lower_timer_control_q.pair_mode_select;
  // bit 15 starts each timer; a timer stopped by idle only if asked.
  // without the stop bit a timer keeps counting through idle and sleep.
  assign lower_enable = lower_timer_control_q.timer_run &
                        ~(lower_timer_control_q.stop_in_idle & idle_in);
  // the upper control word has no effect while paired.
  assign upper_enable = ~pair & upper_timer_control_q.timer_run &
                        ~(upper_timer_control_q.stop_in_idle & idle_in);

  // the lower tick generator drives the cascade, with the lower pins.
  // both generators count pin edges only after synchronisation.
  timer_tick_gen #(
    .PS_WIDTH(PS_WIDTH)
  ) lower_tick (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ctrl_in(lower_timer_control_q),
    .enable_in(lower_enable),
    .pins_in(lower_pins_in),
    .tick_out(tick_lo)
  );

  // each half alone counts the internal clock or its own pin.
  timer_tick_gen #(
    .PS_WIDTH(PS_WIDTH)
  ) upper_tick (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ctrl_in(upper_timer_control_q),
    .enable_in(upper_enable),
    .pins_in(upper_pins_in),
    .tick_out(tick_up)
  );

  // Bus handshake: reads take one wait state so read data come from a flop.
  assign accept = hsel_in & htrans_in[1] & hready_in;
  assign hreadyout_out = (bus_q != BUS_RWAIT);
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;
  assign wr_en = (bus_q == BUS_WRITE);

  // the count pair reads back live at any time.
  always_comb begin
    case (addr_q)
      `OFS_LOWER_CTRL: rd_word = lower_timer_control_q;
      `OFS_UPPER_CTRL: rd_word = upper_timer_control_q;
      `OFS_LOWER_COUNT: rd_word = lower_count_q;
      `OFS_UPPER_COUNT: rd_word = upper_count_q;
      `OFS_LOWER_PERIOD: rd_word = lower_period_q;
      `OFS_UPPER_PERIOD: rd_word = upper_period_q;
      `OFS_IRQ_STATUS: rd_word = {14'h0000, flags_q};
      `OFS_IRQ_CONFIG: rd_word = irq_cfg_q;
      default: rd_word = 16'h0000;
    endcase
  end

  // Bus phase tracking.
  always_comb begin
    bus_d = bus_q;
    addr_d = addr_q;
    hrdata_d = hrdata_q;
    case (bus_q)
      BUS_RWAIT: begin
        bus_d = BUS_RDONE;
        hrdata_d = {16'h0000, rd_word};
      end
      BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
        if (accept) begin
          addr_d = haddr_in[7:0];
          bus_d = hwrite_in ? BUS_WRITE : BUS_RWAIT;
        end else begin
          bus_d = BUS_IDLE;
        end
      end
      default: bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      bus_q <= BUS_IDLE;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      bus_q <= bus_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Counting, matching, flags and software writes.
  always_comb begin
    lower_timer_control_d = lower_timer_control_q;
    upper_timer_control_d = upper_timer_control_q;
    lower_count_d = lower_count_q;
    upper_count_d = upper_count_q;
    lower_period_d = lower_period_q;
    upper_period_d = upper_period_q;
    irq_cfg_d = irq_cfg_q;
    lo_match = 1'b0;
    up_match = 1'b0;
    clr = 2'b00;
    // lower count forms the low word of the cascade.
    count32 = {upper_count_q, lower_count_q};
    // upper period is the high word of the 32-bit period.
    period32 = {upper_period_q, lower_period_q};
    lo_step = step16(lower_count_q, lower_period_q);
    up_step = step16(upper_count_q, upper_period_q);
    // paired, the lower source makes a 32-bit timer or pin counter.
    if (pair) begin
      // a 32-bit match restarts the pair and flags the upper timer.
      // the count returns to zero on the matching tick.
      if (tick_lo) begin
        if (count32 == period32) begin
          lower_count_d = 16'h0000;
          upper_count_d = 16'h0000;
          up_match = 1'b1;
        end else begin
          {upper_count_d, lower_count_d} = count32 + 32'h0000_0001;
        end
      end
    end else begin
      if (tick_lo) begin
        lower_count_d = lo_step[15:0];
        lo_match = lo_step[16];
      end
      if (tick_up) begin
        upper_count_d = up_step[15:0];
        up_match = up_step[16];
      end
    end
    // Software writes land after counting, so a written count is kept.
    if (wr_en) begin
      case (addr_q)
        `OFS_LOWER_CTRL: lower_timer_control_d = hwdata_in[15:0] & `CTRL_WMASK;
        `OFS_UPPER_CTRL: upper_timer_control_d = hwdata_in[15:0] & `CTRL_WMASK;
        `OFS_LOWER_COUNT: lower_count_d = hwdata_in[15:0];
        `OFS_UPPER_COUNT: upper_count_d = hwdata_in[15:0];
        `OFS_LOWER_PERIOD: lower_period_d = hwdata_in[15:0];
        `OFS_UPPER_PERIOD: upper_period_d = hwdata_in[15:0];
        `OFS_IRQ_STATUS: clr = hwdata_in[1:0];
        `OFS_IRQ_CONFIG: irq_cfg_d = hwdata_in[15:0] & `CFG_WMASK;
        default: clr = 2'b00;
      endcase
    end
    // paired matches only ever reach the upper flag.
    // Write-one-to-clear; a match in the same cycle wins over the clear.
    flags_d = (flags_q & ~clr) | {up_match, lo_match};
    // the converter trigger comes from upper matches only.
    adc_d = up_match;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lower_timer_control_q <= `CTRL_RESET;
      upper_timer_control_q <= `CTRL_RESET;
      lower_count_q <= `COUNT_RESET;
      upper_count_q <= `COUNT_RESET;
      lower_period_q <= `PERIOD_RESET;
      upper_period_q <= `PERIOD_RESET;
      flags_q <= 2'b00;
      irq_cfg_q <= `CFG_RESET;
      adc_q <= 1'b0;
    end else begin
      lower_timer_control_q <= lower_timer_control_d;
      upper_timer_control_q <= upper_timer_control_d;
      lower_count_q <= lower_count_d;
      upper_count_q <= upper_count_d;
      lower_period_q <= lower_period_d;
      upper_period_q <= upper_period_d;
      flags_q <= flags_d;
      irq_cfg_q <= irq_cfg_d;
      adc_q <= adc_d;
    end
  end

  // enable and priority are software-programmed, passed to the controller.
  assign lower_irq_out = flags_q[`STAT_LOWER_BIT] & irq_cfg_q[`CFG_LOWER_EN_BIT];
  assign upper_irq_out = flags_q[`STAT_UPPER_BIT] & irq_cfg_q[`CFG_UPPER_EN_BIT];
  assign lower_irq_priority_out = irq_cfg_q[`CFG_LOWER_PRIO_LSB +: 3];
  assign upper_irq_priority_out = irq_cfg_q[`CFG_UPPER_PRIO_LSB +: 3];
  assign adc_trigger_out = adc_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  chk_read_wait_state: assert property (
    (accept && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
    else $error("Read data phase did not take exactly one wait state.");
  chk_upper_ignored: assert property (
    pair |-> !tick_up)
    else $error("Upper timer ticked while paired.");
  chk_pair_wrap: assert property (
    (pair && tick_lo && count32 == period32 && !wr_en) |=>
      lower_count_q == 16'h0000 && upper_count_q == 16'h0000 && flags_q[1] && adc_trigger_out)
    else $error("32-bit match did not restart and flag the upper timer.");
  chk_pair_carry: assert property (
    (pair && tick_lo && count32 != period32 && lower_count_q == 16'hFFFF && !wr_en) |=>
      lower_count_q == 16'h0000 && upper_count_q == $past(upper_count_q) + 16'h0001)
    else $error("Low word overflow did not carry into the high word.");
  chk_pair_no_lower_flag: assert property (
    (pair && !flags_q[0]) |=> !flags_q[0])
    else $error("Lower flag set while paired.");
  chk_lower_no_trigger: assert property (
    (!pair && lo_match && !up_match) |=> !adc_trigger_out)
    else $error("Lower match produced a converter trigger.");
  chk_split_wrap: assert property (
    (!pair && tick_lo && lower_count_q == lower_period_q && !wr_en) |=>
      lower_count_q == 16'h0000 && flags_q[0])
    else $error("16-bit match did not restart the lower count.");
  chk_stopped_holds: assert property (
    (!lower_timer_control_q.timer_run && !wr_en) |=> $stable(lower_count_q))
    else $error("Lower count moved while stopped.");
  chk_prescale_eight: assert property (
    (tick_lo && lower_timer_control_q.prescale_select == 2'b01) |=> (!tick_lo) [*7])
    else $error("Ratio of eight ticked too early.");
  chk_flag_set_wins: assert property (
    (up_match && wr_en && addr_q == `OFS_IRQ_STATUS) |=> flags_q[1])
    else $error("Clear overrode a simultaneous match.");

  cov_pair_wrap: cover property (pair && tick_lo && count32 == period32);
  cov_upper_split_match: cover property (!pair && up_match);
  cov_read: cover property (bus_q == BUS_RDONE);
  cov_gated: cover property (lower_timer_control_q.gated_count_enable && tick_lo);

endmodule
`default_nettype wire

//--- dual_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_defs.svh"

module dual_timer_tb;
  import dual_timer_pkg::*;
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic idle = 1'h0;
  timer_pins_type lower_pins = '0;
  timer_pins_type upper_pins = '0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, lower_irq, upper_irq, adc_trig;
  wire logic [2:0] lower_prio, upper_prio;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h9F8463F2;
  int c;
  logic [31:0] rdata;
  logic [15:0] p, k, a;

  dual_timer #(.PS_WIDTH(8)) DUT (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .lower_pins_in(lower_pins), .upper_pins_in(upper_pins),
    .idle_in(idle), .lower_irq_out(lower_irq), .upper_irq_out(upper_irq),
    .lower_irq_priority_out(lower_prio), .upper_irq_priority_out(upper_prio),
    .adc_trigger_out(adc_trig)
  );

  // Free-running system clock, 40 ns period.
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Samples ready mid-cycle so the edge that takes it is never raced.
  task automatic wait_ready();
    int n;
    logic r;
    n = 0;
    r = 1'h0;
    while (r !== 1'h1) begin
      @(negedge core_clk_in);
      r = hreadyout;
      rdata = hrdata;
      @(posedge core_clk_in);
      n++;
      if (n > 20) begin
        check("bus ready", 32'(r), 32'h1);
        r = 1'h1;
      end
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [15:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    wait_ready();
  endtask

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    xfer(1'h1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] e, input string n);
    xfer(1'h0, ad, 16'h0);
    check(n, rdata, {16'h0, e});
    check("bus response", 32'(hresp), 32'h0);
  endtask

  // Counts cycles up to the next trigger pulse, or to the limit.
  task automatic wait_pulse(input int lim);
    c = 0;
    do begin
      @(negedge core_clk_in);
      c++;
    end while (adc_trig !== 1'h1 && c < lim);
    @(posedge core_clk_in);
  endtask

  function automatic int ratio(input int ps);
    case (ps)
      0: return 1;
      1: return 8;
      2: return 64;
      default: return 256;
    endcase
  endfunction

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (60000) @(posedge core_clk_in);
    miscompares++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4), (i == 4 || i == 5) ? 16'hFFFF : 16'h0000, "reset value");
    end
    check("reset trigger", 32'(adc_trig), 32'h0);
    wr(`OFS_UPPER_CTRL, 16'h7FFF);
    rd(`OFS_UPPER_CTRL, 16'h207A, "control mask");
    wr(`OFS_UPPER_CTRL, 16'h0000);
    wr(`OFS_IRQ_CONFIG, 16'hFFFF);
    rd(`OFS_IRQ_CONFIG, 16'h0773, "config mask");
    check("upper priority", 32'(upper_prio), 32'h7);
    check("lower priority", 32'(lower_prio), 32'h7);
    p = 16'($random(seed));
    k = 16'($random(seed));
    wr(`OFS_LOWER_PERIOD, p);
    wr(`OFS_UPPER_PERIOD, k);
    rd(`OFS_LOWER_PERIOD, p, "lower period");
    rd(`OFS_UPPER_PERIOD, k, "upper period");
    wr(`OFS_IRQ_CONFIG, 16'h0302);
    // Upper timer alone, each prescale ratio, processor idle throughout.
    idle <= 1'h1;
    for (int ps = 0; ps < 4; ps++) begin
      p = 16'(1 + $unsigned($random(seed)) % 4);
      wr(`OFS_UPPER_CTRL, 16'h0000);
      wr(`OFS_UPPER_COUNT, 16'h0000);
      wr(`OFS_UPPER_PERIOD, p);
      wr(`OFS_UPPER_CTRL, 16'h8000 | 16'(ps << 4));
      wait_pulse(3000);
      wait_pulse(3000);
      check("trigger interval", c, (int'(p) + 1) * ratio(ps));
      check("upper flag", 32'(upper_irq), 32'h1);
    end
    // With its stop bit set, the upper timer halts while the processor idles.
    wr(`OFS_UPPER_CTRL, 16'hA000);
    wr(`OFS_UPPER_COUNT, 16'h0000);
    repeat (10) @(posedge core_clk_in);
    rd(`OFS_UPPER_COUNT, 16'h0000, "stop in idle");
    idle <= 1'h0;
    wr(`OFS_UPPER_CTRL, 16'h0000);
    wr(`OFS_IRQ_STATUS, 16'h0002);
    // The flag register updates at the write edge, so look half a cycle later.
    @(negedge core_clk_in);
    check("upper flag cleared", 32'(upper_irq), 32'h0);
    @(posedge core_clk_in);
    // Period zero matches on every tick, so the clear meets a match.
    wr(`OFS_UPPER_PERIOD, 16'h0000);
    wr(`OFS_UPPER_CTRL, 16'h8000);
    wr(`OFS_IRQ_STATUS, 16'h0002);
    @(negedge core_clk_in);
    check("set beats clear", 32'(upper_irq), 32'h1);
    @(posedge core_clk_in);
    wr(`OFS_UPPER_CTRL, 16'h0000);
    wr(`OFS_IRQ_STATUS, 16'h0002);
    // Lower timer alone never makes a trigger.
    wr(`OFS_IRQ_CONFIG, 16'h0001);
    wr(`OFS_LOWER_PERIOD, 16'h0001);
    wr(`OFS_LOWER_CTRL, 16'h8010);
    wait_pulse(40);
    check("lower trigger", c, 40);
    check("lower flag", 32'(lower_irq), 32'h1);
    wr(`OFS_LOWER_CTRL, 16'h0000);
    wr(`OFS_IRQ_STATUS, 16'h0001);
    // Upper timer counting pin edges.
    k = 16'(3 + $unsigned($random(seed)) % 5);
    wr(`OFS_UPPER_PERIOD, 16'hFFFF);
    wr(`OFS_UPPER_COUNT, 16'h0000);
    wr(`OFS_UPPER_CTRL, 16'h8002);
    repeat (k) begin
      upper_pins.ext_clk <= 1'h1;
      repeat (3) @(posedge core_clk_in);
      upper_pins.ext_clk <= 1'h0;
      repeat (3) @(posedge core_clk_in);
    end
    repeat (5) @(posedge core_clk_in);
    rd(`OFS_UPPER_COUNT, k, "pin edge count");
    wr(`OFS_UPPER_CTRL, 16'h0000);
    // Lower timer gated: frozen while the gate is low.
    wr(`OFS_LOWER_PERIOD, 16'hFFFF);
    wr(`OFS_LOWER_COUNT, 16'h0000);
    wr(`OFS_LOWER_CTRL, 16'h8040);
    repeat (10) @(posedge core_clk_in);
    xfer(1'h0, `OFS_LOWER_COUNT, 16'h0);
    a = rdata[15:0];
    check("gate low start", 32'(a), 32'h0);
    repeat (10) @(posedge core_clk_in);
    rd(`OFS_LOWER_COUNT, a, "gate low hold");
    lower_pins.gate <= 1'h1;
    repeat (20) @(posedge core_clk_in);
    xfer(1'h0, `OFS_LOWER_COUNT, 16'h0);
    check("gate high runs", 32'(rdata[15:0] > a + 16'h0010), 32'h1);
    lower_pins.gate <= 1'h0;
    wr(`OFS_LOWER_CTRL, 16'h0000);
    // Paired: carry into the upper word, upper control ignored.
    wr(`OFS_UPPER_CTRL, 16'h0072);
    wr(`OFS_LOWER_PERIOD, 16'hFFFF);
    wr(`OFS_LOWER_COUNT, 16'hFFFE);
    wr(`OFS_UPPER_COUNT, 16'h0000);
    wr(`OFS_LOWER_CTRL, 16'h8008);
    repeat (8) @(posedge core_clk_in);
    rd(`OFS_UPPER_COUNT, 16'h0001, "upper word carry");
    wr(`OFS_LOWER_CTRL, 16'h0008);
    rd(`OFS_LOWER_CTRL, 16'h0008, "pair bit");
    wr(`OFS_LOWER_COUNT, 16'hFFF0);
    wr(`OFS_UPPER_COUNT, 16'h0000);
    wr(`OFS_LOWER_PERIOD, 16'h0004);
    wr(`OFS_UPPER_PERIOD, 16'h0001);
    wr(`OFS_IRQ_CONFIG, 16'h0303);
    wr(`OFS_IRQ_STATUS, 16'h0003);
    check("upper priority set", 32'(upper_prio), 32'h3);
    wr(`OFS_LOWER_CTRL, 16'h8008);
    wait_pulse(60);
    // Ticks from FFF0 up to the period, one matching tick, one to register the trigger.
    check("paired match", c, (32'h0001_0004 - 32'h0000_FFF0) + 32'd2);
    check("paired upper flag", 32'(upper_irq), 32'h1);
    check("paired lower flag", 32'(lower_irq), 32'h0);
    rd(`OFS_UPPER_COUNT, 16'h0000, "paired restart");
    // Paired counter on the lower pin: three edges carry into the high word.
    wr(`OFS_LOWER_CTRL, 16'h0008);
    wr(`OFS_LOWER_PERIOD, 16'hFFFF);
    wr(`OFS_UPPER_PERIOD, 16'hFFFF);
    wr(`OFS_LOWER_COUNT, 16'hFFFE);
    wr(`OFS_UPPER_COUNT, 16'h0000);
    wr(`OFS_LOWER_CTRL, 16'h800A);
    repeat (3) begin
      lower_pins.ext_clk <= 1'h1;
      repeat (3) @(posedge core_clk_in);
      lower_pins.ext_clk <= 1'h0;
      repeat (3) @(posedge core_clk_in);
    end
    repeat (5) @(posedge core_clk_in);
    rd(`OFS_LOWER_COUNT, 16'h0001, "paired pin low word");
    rd(`OFS_UPPER_COUNT, 16'h0001, "paired pin high word");
    wr(`OFS_LOWER_CTRL, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
